// file: rtl/qpv_pkg.sv
//
// Purpose: shared constants and types for the quadrature position/velocity block
// Assumes: one 10 MHz clock, synchronous active-high reset
// Notes:   interrupt bit order is index, timer, direction, error
//
package qpv_pkg;

    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned POS_W        = 32;
    localparam int unsigned VEL_W        = 32;
    localparam int unsigned NUM_IRQ      = 4;

    // interrupt bit positions
    localparam int unsigned IRQ_INDEX    = 0;
    localparam int unsigned IRQ_TIMER    = 1;
    localparam int unsigned IRQ_DIR      = 2;
    localparam int unsigned IRQ_ERROR    = 3;

    // values after reset
    localparam logic [31:0] POS_RST      = 32'h0000_0000;
    localparam logic [31:0] VEL_RST      = 32'h0000_0000;
    localparam logic [3:0]  IRQ_RST      = 4'h0;

    // input synchroniser depth
    localparam int unsigned SYNC_STAGES  = 3;

    // configuration carried as one bundle
    typedef struct packed {
        logic pos_en;      // position capture enable
        logic vel_en;      // velocity capture enable
        logic clk_dir;     // 1: clock/direction, 0: phase mode
        logic both_edges;  // count edges of both channels
        logic swap;        // swap channel inputs
        logic idx_reset;   // reset position on index
    } qpv_cfg_t;

    // one decoded step from the decoder
    typedef struct packed {
        logic step;        // one count this cycle
        logic fwd;         // direction of that count
        logic err;         // both phases changed together
        logic index;       // index rising edge
    } qpv_step_t;

endpackage : qpv_pkg

// file: rtl/qpv_sync.sv
//
// Purpose: three-flop synchroniser with agreement filter for encoder pins
// Assumes: inputs are asynchronous to CLK
// Notes:   output changes only when stages two and three agree
//
`timescale 1ns/1ps
module qpv_sync
    import qpv_pkg::*;
#(
    parameter int unsigned W = 3
) (
    input  wire logic         CLK,    // system clock
    input  wire logic         RESET,  // synchronous reset
    input  wire logic [W-1:0] din,    // raw pins
    output logic      [W-1:0] dout    // filtered level
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // synchroniser chain; first stage feeds only the second
    always_ff @(posedge CLK) begin
        if (RESET) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // accept a bit once stages two and three agree
    always_ff @(posedge CLK) begin
        if (RESET) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    dout[i] <= s3_q[i];
                end
            end
        end
    end

endmodule : qpv_sync

// file: rtl/qpv_decode.sv
//
// Purpose: channel swap and phase or clock/direction decode into steps
// Assumes: inputs already synchronised to CLK
// Notes:   output step bundle is registered, one cycle after the edge
//
`timescale 1ns/1ps
module qpv_decode
    import qpv_pkg::*;
(
    input  wire logic      CLK,    // system clock
    input  wire logic      RESET,  // synchronous reset
    input  qpv_cfg_t       cfg,    // configuration
    input  wire logic      ch_a,   // channel A level
    input  wire logic      ch_b,   // channel B level
    input  wire logic      idx,    // index level
    output qpv_step_t      st      // decoded step
);

    logic idx_q;
    logic pa;
    logic pb;
    logic pa_q;
    logic pb_q;
    logic ea;
    logic eb;

    // swap before any decoding
    assign pa = cfg.swap ? ch_b : ch_a;
    assign pb = cfg.swap ? ch_a : ch_b;
    assign ea = pa ^ pa_q;
    assign eb = pb ^ pb_q;

    // previous levels
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pa_q  <= 1'b0;
            pb_q  <= 1'b0;
            idx_q <= 1'b0;
        end else begin
            pa_q  <= pa;
            pb_q  <= pb;
            idx_q <= idx;
        end
    end

    // step generation per mode
    always_ff @(posedge CLK) begin
        if (RESET) begin
            st <= '0;
        end else begin
            st.index <= idx & ~idx_q;
            if (cfg.clk_dir) begin
                st.step <= pa & ~pa_q;
                st.fwd  <= ~pb;
                st.err  <= 1'b0;
            end else begin
                st.err  <= ea & eb;
                st.step <= (ea ^ eb) & (ea | cfg.both_edges);
                // leading channel: A edge to differing levels means forward
                st.fwd  <= ea ? (pa ^ pb) : ~(pa ^ pb);
            end
        end
    end

endmodule : qpv_decode

// file: rtl/qpv_top.sv
//
// Purpose: quadrature position and velocity capture with event flags
// Assumes: encoder pins asynchronous; control bits are plain ports
// Notes:   Functional notes below
`timescale 1ns/1ps
module qpv_top
    import qpv_pkg::*;
#(
    parameter int unsigned PW = POS_W,
    parameter int unsigned VW = VEL_W
) (
    input  wire logic          CLK,          // 10 MHz system clock
    input  wire logic          RESET,        // synchronous, active high
    input  wire logic          ENC_A,        // encoder channel A pin
    input  wire logic          ENC_B,        // encoder channel B pin
    input  wire logic          ENC_IDX,      // encoder index pin
    input  qpv_cfg_t           CFG,          // configuration bundle
    input  wire logic [PW-1:0] MAX_POS,      // maximum position
    input  wire logic [VW-1:0] VEL_PERIOD,   // timer period in clocks minus one
    input  wire logic          POS_WR,       // load position pulse
    input  wire logic [PW-1:0] POS_WDATA,    // position load value
    input  wire logic [3:0]    IRQ_MASK,     // per-source enables
    input  wire logic [3:0]    IRQ_CLR,      // write-one-to-clear pulse
    output logic      [PW-1:0] POSITION,     // position count
    output logic      [VW-1:0] VEL_RUNNING,  // running period total
    output logic      [VW-1:0] VEL_LATCHED,  // previous period total
    output logic               DIRECTION,    // last direction, 1 forward
    output logic               PHASE_ERR,    // sticky phase error
    output logic      [3:0]    IRQ_RAW,      // raw event status
    output logic      [3:0]    IRQ_MASKED,   // masked event status
    output logic               IRQ           // interrupt line
);

    ////////////////////////////////////////////////////////////////////////
    // input conditioning and decode

    logic [2:0] pins_s;
    qpv_step_t  st;
    qpv_cfg_t   dcfg;

    qpv_sync #(.W(3)) u_sync (
        .CLK   (CLK),
        .RESET (RESET),
        .din   ({ENC_IDX, ENC_B, ENC_A}),
        .dout  (pins_s)
    );

    qpv_decode u_dec (
        .CLK   (CLK),
        .RESET (RESET),
        .cfg   (dcfg),
        .ch_a  (pins_s[0]),
        .ch_b  (pins_s[1]),
        .idx   (pins_s[2]),
        .st    (st)
    );

    assign dcfg = CFG;

    ////////////////////////////////////////////////////////////////////////
    // position counter

    logic cnt;
    logic vel_on;
    logic tick;
    logic [VW-1:0] tmr_q;
    logic [3:0]    ev;

    assign cnt    = CFG.pos_en & st.step;
    assign vel_on = CFG.pos_en & CFG.vel_en;

    // next position with wrap at the programmed maximum
    function automatic logic [PW-1:0] step_pos(input logic [PW-1:0] p,
                                               input logic fwd,
                                               input logic [PW-1:0] mx);
        if (fwd) begin
            step_pos = (p >= mx) ? '0 : p + 1'b1;
        end else begin
            step_pos = (p == '0) ? mx : p - 1'b1;
        end
    endfunction : step_pos

    // position update, index reset and software load
    always_ff @(posedge CLK) begin
        if (RESET) begin
            POSITION <= POS_RST[PW-1:0];
        end else if (POS_WR) begin
            POSITION <= POS_WDATA;
        end else if (CFG.pos_en && CFG.idx_reset && st.index) begin
            POSITION <= DIRECTION ? '0 : MAX_POS;
        end else if (cnt) begin
            POSITION <= step_pos(POSITION, st.fwd, MAX_POS);
        end
    end

    // last direction, kept after motion stops
    always_ff @(posedge CLK) begin
        if (RESET) begin
            DIRECTION <= 1'b1;
        end else if (cnt) begin
            DIRECTION <= st.fwd;
        end
    end

    // sticky phase error
    always_ff @(posedge CLK) begin
        if (RESET) begin
            PHASE_ERR <= 1'b0;
        end else if (CFG.pos_en && st.err) begin
            PHASE_ERR <= 1'b1;
        end else if (IRQ_CLR[IRQ_ERROR]) begin
            PHASE_ERR <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // velocity timer and accumulator

    assign tick = vel_on && (tmr_q == '0);

    // down-counting period timer
    always_ff @(posedge CLK) begin
        if (RESET) begin
            tmr_q <= VEL_PERIOD;     // full first period, no expiry right after reset
        end else if (!vel_on) begin
            tmr_q <= VEL_PERIOD;
        end else if (tmr_q == '0) begin
            tmr_q <= VEL_PERIOD;
        end else begin
            tmr_q <= tmr_q - 1'b1;
        end
    end

    // pulse totals: running and latched at expiry
    always_ff @(posedge CLK) begin
        if (RESET) begin
            VEL_RUNNING <= VEL_RST[VW-1:0];
            VEL_LATCHED <= VEL_RST[VW-1:0];
        end else if (!vel_on) begin
            VEL_RUNNING <= '0;
        end else if (tick) begin
            VEL_LATCHED <= VEL_RUNNING + VW'(cnt);
            VEL_RUNNING <= '0;
        end else if (cnt) begin
            VEL_RUNNING <= VEL_RUNNING + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event status, set beats clear

    assign ev[IRQ_INDEX] = CFG.pos_en & st.index;
    assign ev[IRQ_TIMER] = tick;
    assign ev[IRQ_DIR]   = cnt & (st.fwd != DIRECTION);
    assign ev[IRQ_ERROR] = CFG.pos_en & st.err;

    // raw sticky status
    always_ff @(posedge CLK) begin
        if (RESET) begin
            IRQ_RAW <= IRQ_RST;
        end else begin
            IRQ_RAW <= (IRQ_RAW & ~IRQ_CLR) | ev;
        end
    end

    // masked view and line
    always_ff @(posedge CLK) begin
        if (RESET) begin
            IRQ_MASKED <= IRQ_RST;
            IRQ        <= 1'b0;
        end else begin
            IRQ_MASKED <= ((IRQ_RAW & ~IRQ_CLR) | ev) & IRQ_MASK;
            IRQ        <= |(((IRQ_RAW & ~IRQ_CLR) | ev) & IRQ_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    property p_raw_set;
        @(posedge CLK) disable iff (RESET) ev[IRQ_TIMER] |=> IRQ_RAW[IRQ_TIMER];
    endproperty
    a_raw_set: assert property (p_raw_set) else $error("timer event not flagged");

    property p_mask_and;
        @(posedge CLK) disable iff (RESET) 1'b1 |=> (IRQ_MASKED == (IRQ_RAW & $past(IRQ_MASK)));
    endproperty
    a_mask_and: assert property (p_mask_and) else $error("masked view wrong");

    property p_irq_line;
        @(posedge CLK) disable iff (RESET) IRQ == (|IRQ_MASKED);
    endproperty
    a_irq_line: assert property (p_irq_line) else $error("irq line mismatch");

    property p_vel_off;
        @(posedge CLK) disable iff (RESET) !CFG.pos_en |=> VEL_RUNNING == '0;
    endproperty
    a_vel_off: assert property (p_vel_off) else $error("velocity ran while disabled");

    property p_latch;
        @(posedge CLK) disable iff (RESET)
            (tick && !cnt) |=> VEL_LATCHED == $past(VEL_RUNNING) && VEL_RUNNING == '0;
    endproperty
    a_latch: assert property (p_latch) else $error("period total not latched");

    property p_fwd_step;
        @(posedge CLK) disable iff (RESET)
            (cnt && st.fwd && !POS_WR && !(CFG.idx_reset && st.index) && POSITION < MAX_POS)
            |=> POSITION == $past(POSITION) + 1'b1;
    endproperty
    a_fwd_step: assert property (p_fwd_step) else $error("forward step lost");

    property p_rev_idx;
        @(posedge CLK) disable iff (RESET)
            (!POS_WR && CFG.pos_en && CFG.idx_reset && st.index && !DIRECTION)
            |=> POSITION == $past(MAX_POS);
    endproperty
    a_rev_idx: assert property (p_rev_idx) else $error("reverse index load wrong");

    property p_no_idx;
        @(posedge CLK) disable iff (RESET)
            (!CFG.idx_reset && !POS_WR && !cnt) |=> POSITION == $past(POSITION);
    endproperty
    a_no_idx: assert property (p_no_idx) else $error("position moved without step");

    property p_dir_hold;
        @(posedge CLK) disable iff (RESET) !cnt |=> $stable(DIRECTION);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("direction changed idle");

    property p_err;
        @(posedge CLK) disable iff (RESET) (CFG.pos_en && st.err) |=> PHASE_ERR;
    endproperty
    a_err: assert property (p_err) else $error("phase error not held");

    property p_tmr_reload;
        @(posedge CLK) disable iff (RESET) tick |=> tmr_q == $past(VEL_PERIOD);
    endproperty
    a_tmr_reload: assert property (p_tmr_reload) else $error("timer not reloaded");

    property p_tmr_down;
        @(posedge CLK) disable iff (RESET)
            (vel_on && (tmr_q != '0)) |=> tmr_q == $past(tmr_q) - 1'b1;
    endproperty
    a_tmr_down: assert property (p_tmr_down) else $error("timer did not count");

    property p_run_count;
        @(posedge CLK) disable iff (RESET)
            (vel_on && !tick && cnt) |=> VEL_RUNNING == $past(VEL_RUNNING) + 1'b1;
    endproperty
    a_run_count: assert property (p_run_count) else $error("pulse not summed");

    property p_dir_evt;
        @(posedge CLK) disable iff (RESET)
            (cnt && (st.fwd != DIRECTION)) |=> IRQ_RAW[IRQ_DIR];
    endproperty
    a_dir_evt: assert property (p_dir_evt) else $error("direction event lost");

    property p_idx_evt;
        @(posedge CLK) disable iff (RESET) ev[IRQ_INDEX] |=> IRQ_RAW[IRQ_INDEX];
    endproperty
    a_idx_evt: assert property (p_idx_evt) else $error("index event lost");

    property p_clr;
        @(posedge CLK) disable iff (RESET)
            (IRQ_CLR[IRQ_INDEX] && !ev[IRQ_INDEX]) |=> !IRQ_RAW[IRQ_INDEX];
    endproperty
    a_clr: assert property (p_clr) else $error("index status not cleared");

    property p_sw_load;
        @(posedge CLK) disable iff (RESET) POS_WR |=> POSITION == $past(POS_WDATA);
    endproperty
    a_sw_load: assert property (p_sw_load) else $error("position load lost");

    property p_fwd_idx;
        @(posedge CLK) disable iff (RESET)
            (!POS_WR && CFG.pos_en && CFG.idx_reset && st.index && DIRECTION) |=> POSITION == '0;
    endproperty
    a_fwd_idx: assert property (p_fwd_idx) else $error("forward index reset wrong");

    c_tick:  cover property (@(posedge CLK) disable iff (RESET) tick);
    c_idx:   cover property (@(posedge CLK) disable iff (RESET) ev[IRQ_INDEX]);
    c_dir:   cover property (@(posedge CLK) disable iff (RESET) ev[IRQ_DIR]);
    c_irq:   cover property (@(posedge CLK) disable iff (RESET) $rose(IRQ));
    c_err:   cover property (@(posedge CLK) disable iff (RESET) ev[IRQ_ERROR]);

endmodule : qpv_top

// file: bench/qpv_enc_model.sv
//
// Purpose: encoder stand-in driving the channel and index pins
// Assumes: pins change at a falling edge and then hold HOLD clocks
// Notes:   phase order 00,10,11,01 (A,B) is forward motion
//
`timescale 1ns/1ps
module qpv_enc_model #(
    parameter int HOLD = 8
) (
    input  wire logic CLK,  // system clock
    output logic      A,    // channel A pin
    output logic      B,    // channel B pin
    output logic      IDX   // index pin
);
    int ph;  // quadrature phase 0..3

    ////////////////////////////////////////////////////////////////////////////
    // idle pins from time zero
    initial begin
        A = 1'b0;
        B = 1'b0;
        IDX = 1'b0;
        ph = 0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // set pins, then hold them long enough for the filter
    task automatic put(input logic a, input logic b, input logic i);
        @(negedge CLK);
        A = a;
        B = b;
        IDX = i;
        repeat (HOLD) @(negedge CLK);
    endtask : put

    // one quadrature step, channels 90 degrees apart
    task automatic qstep(input logic fwd);
        ph = fwd ? (ph + 1) % 4 : (ph + 3) % 4;
        put(ph == 1 || ph == 2, ph >= 2, 1'b0);
    endtask : qstep

    // one clock/direction step, direction low is forward
    task automatic cstep(input logic fwd);
        put(1'b0, !fwd, 1'b0);
        put(1'b1, !fwd, 1'b0);
        put(1'b0, !fwd, 1'b0);
    endtask : cstep

    // return both channels low
    task automatic park();
        ph = 0;
        put(1'b0, 1'b0, 1'b0);
    endtask : park

    // single index pulse
    task automatic pulse_idx();
        put(A, B, 1'b1);
        put(A, B, 1'b0);
    endtask : pulse_idx

    // both channels flip in one instant
    task automatic glitch();
        ph = (ph + 2) % 4;
        put(ph == 1 || ph == 2, ph >= 2, 1'b0);
    endtask : glitch
endmodule : qpv_enc_model

// file: bench/qpv_top_tb.sv
//
// Purpose: self-checking bench for the quadrature position/velocity block
// Assumes: encoder model drives the pins, bench drives control at falling edge
// Notes:   velocity period shortened to 200 clocks, later to 100 clocks
//
`timescale 1ns/1ps
module qpv_top_tb;
    import qpv_pkg::*;
    logic        CLK, RESET, ENC_A, ENC_B, ENC_IDX, POS_WR, DIRECTION, PHASE_ERR, IRQ;
    qpv_cfg_t    CFG;
    logic [31:0] MAX_POS, VEL_PERIOD, POS_WDATA, POSITION, VEL_RUNNING, VEL_LATCHED;
    logic [3:0]  IRQ_MASK, IRQ_CLR, IRQ_RAW, IRQ_MASKED;
    int          err_count, n_checks, k;

    ////////////////////////////////////////////////////////////////////////////
    // design and encoder model
    qpv_top qpv_top_inst (
        .CLK(CLK), .RESET(RESET), .ENC_A(ENC_A), .ENC_B(ENC_B), .ENC_IDX(ENC_IDX),
        .CFG(CFG), .MAX_POS(MAX_POS), .VEL_PERIOD(VEL_PERIOD), .POS_WR(POS_WR),
        .POS_WDATA(POS_WDATA), .IRQ_MASK(IRQ_MASK), .IRQ_CLR(IRQ_CLR),
        .POSITION(POSITION), .VEL_RUNNING(VEL_RUNNING), .VEL_LATCHED(VEL_LATCHED),
        .DIRECTION(DIRECTION), .PHASE_ERR(PHASE_ERR), .IRQ_RAW(IRQ_RAW),
        .IRQ_MASKED(IRQ_MASKED), .IRQ(IRQ)
    );
    qpv_enc_model qpv_enc_model_inst (.CLK(CLK), .A(ENC_A), .B(ENC_B), .IDX(ENC_IDX));

    ////////////////////////////////////////////////////////////////////////////
    // compare a word
    task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_w

    // compare a flag
    task automatic chk_b(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_b

    // one-cycle clear pulse
    task automatic clr(input logic [3:0] m);
        IRQ_CLR = m;
        @(negedge CLK);
        IRQ_CLR = 4'h0;
        repeat (2) @(negedge CLK);
    endtask : clr

    // wait for the timer event, bounded
    task automatic wait_tmr();
        clr(4'b0010);
        for (k = 0; k < 400 && IRQ_RAW[1] !== 1'b1; k++) @(negedge CLK);
        chk_b("timer event", 1'b1, IRQ_RAW[1]);
        @(negedge CLK);
    endtask : wait_tmr

    // counts, verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////
    // 10 MHz clock
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    // watchdog against a hang
    initial begin
        #2_000_000;
        err_count++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        RESET = 1'b1;
        CFG = '0;
        MAX_POS = 32'h0000_03E8;
        VEL_PERIOD = 32'h0000_00C7;
        POS_WR = 1'b0;
        POS_WDATA = 32'h0000_0000;
        IRQ_MASK = 4'h0;
        IRQ_CLR = 4'h0;
        err_count = 0;
        n_checks = 0;
        repeat (5) @(negedge CLK);
        RESET = 1'b0;
        chk_w("position", 32'h0000_0000, POSITION);
        chk_b("direction", 1'b1, DIRECTION);
        chk_w("irq raw", 32'h0000_0000, {28'h0, IRQ_RAW});
        CFG.pos_en = 1'b1;
        CFG.both_edges = 1'b1;
        repeat (4) qpv_enc_model_inst.qstep(1'b1);
        chk_w("position", 32'h0000_0004, POSITION);
        repeat (2) qpv_enc_model_inst.qstep(1'b0);
        chk_w("position", 32'h0000_0002, POSITION);
        chk_b("direction event", 1'b1, IRQ_RAW[2]);
        repeat (20) @(negedge CLK);
        chk_b("direction", 1'b0, DIRECTION);
        CFG.both_edges = 1'b0;
        repeat (4) qpv_enc_model_inst.qstep(1'b1);
        chk_w("position", 32'h0000_0004, POSITION);
        CFG.both_edges = 1'b1;
        CFG.swap = 1'b1;
        repeat (4) qpv_enc_model_inst.qstep(1'b1);
        chk_w("position", 32'h0000_0000, POSITION);
        CFG.swap = 1'b0;
        CFG.clk_dir = 1'b1;
        qpv_enc_model_inst.cstep(1'b1);
        qpv_enc_model_inst.cstep(1'b1);
        qpv_enc_model_inst.cstep(1'b0);
        chk_w("position", 32'h0000_0001, POSITION);
        qpv_enc_model_inst.park();
        CFG.clk_dir = 1'b0;
        CFG.pos_en = 1'b0;
        repeat (2) qpv_enc_model_inst.qstep(1'b1);
        chk_w("position", 32'h0000_0001, POSITION);
        CFG.pos_en = 1'b1;
        qpv_enc_model_inst.pulse_idx();
        chk_w("position", 32'h0000_0001, POSITION);
        chk_b("index event", 1'b1, IRQ_RAW[0]);
        qpv_enc_model_inst.qstep(1'b1);
        CFG.idx_reset = 1'b1;
        qpv_enc_model_inst.pulse_idx();
        chk_w("position", 32'h0000_0000, POSITION);
        qpv_enc_model_inst.qstep(1'b0);
        chk_w("position", 32'h0000_03E8, POSITION);
        qpv_enc_model_inst.qstep(1'b0);
        qpv_enc_model_inst.pulse_idx();
        chk_w("position", 32'h0000_03E8, POSITION);
        qpv_enc_model_inst.qstep(1'b1);
        chk_w("position", 32'h0000_0000, POSITION);
        CFG.idx_reset = 1'b0;
        POS_WDATA = 32'h0000_0010;
        POS_WR = 1'b1;
        @(negedge CLK);
        POS_WR = 1'b0;
        @(negedge CLK);
        chk_w("position load", 32'h0000_0010, POSITION);
        qpv_enc_model_inst.glitch();
        chk_w("position", 32'h0000_0010, POSITION);
        chk_b("phase error", 1'b1, PHASE_ERR);
        chk_b("error event", 1'b1, IRQ_RAW[3]);
        MAX_POS = 32'h0000_0011;
        repeat (2) qpv_enc_model_inst.qstep(1'b1);
        chk_w("position", 32'h0000_0000, POSITION);
        IRQ_MASK = 4'b1000;
        repeat (3) @(negedge CLK);
        chk_w("irq masked", 32'h0000_0008, {28'h0, IRQ_MASKED});
        chk_b("irq line", 1'b1, IRQ);
        IRQ_MASK = 4'b0010;
        repeat (3) @(negedge CLK);
        chk_b("irq line", 1'b0, IRQ);
        clr(4'b1101);
        chk_w("irq raw", 32'h0000_0000, {28'h0, IRQ_RAW});
        chk_b("phase error", 1'b0, PHASE_ERR);
        CFG.vel_en = 1'b1;
        wait_tmr();
        repeat (3) qpv_enc_model_inst.qstep(1'b1);
        chk_w("vel running", 32'h0000_0003, VEL_RUNNING);
        VEL_PERIOD = 32'h0000_0063;
        wait_tmr();
        chk_w("vel latched", 32'h0000_0003, VEL_LATCHED);
        chk_w("vel running", 32'h0000_0000, VEL_RUNNING);
        chk_w("irq masked", 32'h0000_0002, {28'h0, IRQ_MASKED});
        wait_tmr();
        chk_w("timer period", 32'h0000_0060, k);
        chk_w("vel latched", 32'h0000_0000, VEL_LATCHED);
        CFG.pos_en = 1'b0;
        repeat (3) @(negedge CLK);
        clr(4'b0010);
        repeat (300) @(negedge CLK);
        chk_b("timer event", 1'b0, IRQ_RAW[1]);
        qpv_enc_model_inst.park();
        RESET = 1'b1;
        repeat (5) @(negedge CLK);
        RESET = 1'b0;
        chk_w("position", 32'h0000_0000, POSITION);
        chk_b("direction", 1'b1, DIRECTION);
        CFG.pos_en = 1'b1;
        qpv_enc_model_inst.qstep(1'b1);
        chk_w("position", 32'h0000_0001, POSITION);
        final_report();
    end
endmodule : qpv_top_tb
